// ==== rtl/spi_port_defs.svh ====
// Constants for the serial peripheral port: widths, depths, thresholds.
// Included by the port module only; holds definitions only.
`ifndef SPI_PORT_DEFS_SVH
`define SPI_PORT_DEFS_SVH
`define SPI_DATA_W 16
`define SPI_FIFO_DEPTH 8
`define SPI_WSIZE_W 4
`define SPI_BAUD_W 3
`define SPI_DIV_W 8
`define SPI_EDGE_W 5
`define SPI_PIN_CNT 4
`define SPI_RX_THR_LOW 4'h1
`define SPI_RX_THR_HIGH 4'h2
`define SPI_WSIZE_RST 4'h7
`endif

// ==== rtl/spi_port_pkg.sv ====
// Types for the serial peripheral port.
// Assumes nothing beyond the constants header.
package spi_port_pkg;
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_GAP = 4'b1000
  } spi_state_e;
endpackage

// ==== rtl/spi_pin_sync.sv ====
// Three-stage synchroniser for pin inputs with an agreement filter.
// Assumes inputs are asynchronous to core_clk.
`timescale 1ns/1ps
module spi_pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  logic [WIDTH-1:0] agree;
  // Only the later stages are compared; stage one feeds stage two alone
  assign agree = ~(stage2_q ^ stage3_q);
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
      pinOut <= '0;
    end
    else
    begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      pinOut <= (stage3_q & agree) | (pinOut & ~agree);
    end
  end
endmodule

// ==== rtl/spi_word_fifo.sv ====
// Synchronous word FIFO in flip-flops with valid/ready on both sides.
// Assumes one clock for both sides.
`timescale 1ns/1ps
module spi_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  localparam int AW = $clog2(DEPTH)
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [AW:0] level
);
  localparam logic [AW:0] FULL = DEPTH[AW:0];
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  wire doPush = inValid && inReady;
  wire doPop = outValid && outReady;
  assign inReady = (count_q != FULL);
  assign outValid = (count_q != '0);
  assign outData = mem_q[rdPtr_q];
  assign level = count_q;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (doPush)
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      if (doPop)
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      if (doPush && !doPop)
        count_q <= count_q + 1'b1;
      else if (doPop && !doPush)
        count_q <= count_q - 1'b1;
    end
  end
  // Storage carries no reset; contents are don't-care until written
  always_ff @(posedge core_clk)
  begin
    if (doPush)
      mem_q[wrPtr_q] <= inData;
  end
endmodule

// ==== rtl/spi_port.sv ====
// Serial peripheral port, master or slave, with transmit and receive FIFOs.
// Assumes configuration inputs are quasi-static from core_clk logic; pins are
// asynchronous and pass the synchroniser. Pin triples resolve outside.
`timescale 1ns/1ps
`include "spi_port_defs.svh"
module spi_port #(
  parameter int DATA_W = `SPI_DATA_W,
  parameter int FIFO_DEPTH = `SPI_FIFO_DEPTH,
  localparam int LW = $clog2(FIFO_DEPTH) + 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic port_enable,
  input wire logic master_select,
  input wire logic clkPolarity,
  input wire logic clkPhase,
  input wire logic low_bit_first,
  input wire logic [`SPI_WSIZE_W-1:0] word_size,
  input wire logic [`SPI_BAUD_W-1:0] baud_divider,
  input wire logic rx_fill_threshold,
  input wire logic soft_select_manage,
  input wire logic internal_select_level,
  input wire logic select_output_enable,
  input wire logic receive_only,
  input wire logic bidir_line_enable,
  input wire logic bidir_output_enable,
  input wire logic select_pulse_enable,
  input wire logic [DATA_W-1:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic [DATA_W-1:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  output logic rx_not_empty_flag,
  output logic tx_empty_flag,
  output logic busy_flag,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  input wire logic nssIn,
  output logic nssOut,
  output logic nssOe
);
  import spi_port_pkg::*;

  spi_state_e state_q;
  logic [`SPI_PIN_CNT-1:0] pinSync;
  logic [`SPI_DIV_W-1:0] div_q;
  logic [`SPI_EDGE_W-1:0] edgeCnt_q;
  logic [DATA_W-1:0] txWord_q;
  logic [DATA_W-1:0] rxWord_q;
  logic dataBit_q;
  logic slaveLoaded_q;
  logic sckPrev_q;
  logic sckOut_q;
  logic sckOe_q;
  logic mosiOe_q;
  logic misoOe_q;
  logic nssOut_q;
  logic nssOe_q;
  logic rxFlag_q;
  logic txFlag_q;
  logic busy_q;
  logic [DATA_W-1:0] txFifoData;
  logic txFifoValid;
  logic rxFifoReady;
  logic [LW-1:0] txLevel;
  logic [LW-1:0] rxLevel;

  function automatic logic [`SPI_WSIZE_W-1:0] bitPos(input logic [`SPI_WSIZE_W-1:0] idx,
      input logic lsbFirst, input logic [`SPI_WSIZE_W-1:0] wsize);
    bitPos = lsbFirst ? idx : wsize - idx;
  endfunction

  spi_pin_sync #(
    .WIDTH(`SPI_PIN_CNT)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pinIn({sckIn, mosiIn, misoIn, nssIn}),
    .pinOut(pinSync)
  );

  wire sckS = pinSync[3];
  wire mosiS = pinSync[2];
  wire misoS = pinSync[1];
  wire nssS = pinSync[0];

  // Mode decode
  wire isMaster = port_enable && master_select;
  wire isSlave = port_enable && !master_select;
  wire bidirRx = bidir_line_enable && !bidir_output_enable;
  wire contRx = (receive_only && !bidir_line_enable) || bidirRx;
  wire sendOn = !receive_only && (!bidir_line_enable || bidir_output_enable);
  wire recvOn = !bidir_line_enable || !bidir_output_enable;
  wire serialIn = master_select ? (bidir_line_enable ? mosiS : misoS)
                                : (bidir_line_enable ? misoS : mosiS);
  wire slaveSel = soft_select_manage ? !internal_select_level : !nssS;

  // Master baud tick: half SCK period is 2^baud_divider core cycles
  wire [`SPI_DIV_W-1:0] halfLimit = (`SPI_DIV_W'(1) << baud_divider) - 1'b1;
  wire tick = (div_q == halfLimit);
  wire masterEdge = (state_q == ST_SHIFT) && tick;
  wire slaveEdge = isSlave && slaveSel && (sckS != sckPrev_q);
  wire anyEdge = masterEdge || slaveEdge;

  // Frame bookkeeping: 2*(word_size+1) edges per frame
  wire [`SPI_EDGE_W-1:0] lastEdge = {word_size, 1'b1};
  wire frameEnd = anyEdge && (edgeCnt_q == lastEdge);
  wire sampleEdge = anyEdge && (edgeCnt_q[0] == clkPhase);
  wire shiftEdge = anyEdge && !sampleEdge && !frameEnd;
  wire [`SPI_WSIZE_W-1:0] curIdx = edgeCnt_q[`SPI_EDGE_W-1:1];
  wire [`SPI_WSIZE_W-1:0] shiftIdx = curIdx + {3'b000, edgeCnt_q[0]};
  wire [`SPI_WSIZE_W-1:0] rxPos = bitPos(curIdx, low_bit_first, word_size);
  wire [`SPI_WSIZE_W-1:0] txPos = bitPos(shiftIdx, low_bit_first, word_size);
  wire [`SPI_WSIZE_W-1:0] firstPos = bitPos('0, low_bit_first, word_size);
  wire [DATA_W-1:0] rxMask = DATA_W'(1) << rxPos;
  wire [DATA_W-1:0] rxWordD = sampleEdge ? ((rxWord_q & ~rxMask) | ({DATA_W{serialIn}} & rxMask))
                                         : rxWord_q;

  // Transmit FIFO pop: master on load, slave between frames
  wire masterStart = isMaster && (txFifoValid || contRx) && (rxFifoReady || !recvOn);
  wire masterPop = (state_q == ST_LOAD) && txFifoValid && sendOn;
  wire slaveLoad = isSlave && slaveSel && !slaveLoaded_q && ~|edgeCnt_q && txFifoValid && sendOn;
  wire txPop = masterPop || slaveLoad;
  wire [DATA_W-1:0] loadWord = txPop ? txFifoData : '0;
  wire rxPush = frameEnd && recvOn;
  wire [`SPI_WSIZE_W-1:0] rxThr = rx_fill_threshold ? `SPI_RX_THR_HIGH : `SPI_RX_THR_LOW;
  wire pulseGap = (state_q == ST_GAP) && select_pulse_enable;
  wire busyD = isMaster ? ((state_q != ST_IDLE) || contRx)
                        : (isSlave && slaveSel && (edgeCnt_q != '0));

  spi_word_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_txfifo (
    .core_clk(core_clk),
    .rst(rst),
    .inValid(txValid),
    .inReady(txReady),
    .inData(txData),
    .outValid(txFifoValid),
    .outReady(txPop),
    .outData(txFifoData),
    .level(txLevel)
  );

  // A full receive FIFO drops the frame; a master waits for room first
  spi_word_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rxfifo (
    .core_clk(core_clk),
    .rst(rst),
    .inValid(rxPush),
    .inReady(rxFifoReady),
    .inData(rxWordD),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData(rxData),
    .level(rxLevel)
  );

  // Master sequencer
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      div_q <= '0;
    end
    else if (!isMaster)
    begin
      state_q <= ST_IDLE;
      div_q <= '0;
    end
    else
    begin
      div_q <= (tick || state_q == ST_IDLE || state_q == ST_LOAD) ? '0 : div_q + 1'b1;
      case (state_q)
        ST_IDLE: state_q <= masterStart ? ST_LOAD : ST_IDLE;
        ST_LOAD: state_q <= ST_SHIFT;
        ST_SHIFT: state_q <= frameEnd ? ST_GAP : ST_SHIFT;
        ST_GAP: state_q <= !tick ? ST_GAP : (masterStart ? ST_LOAD : ST_IDLE);
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Shared shifter for both roles
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      edgeCnt_q <= '0;
      txWord_q <= '0;
      rxWord_q <= '0;
      dataBit_q <= 1'b0;
      slaveLoaded_q <= 1'b0;
      sckPrev_q <= 1'b0;
    end
    else
    begin
      sckPrev_q <= sckS;
      if (!port_enable || (isSlave && !slaveSel) || state_q == ST_LOAD)
      begin
        edgeCnt_q <= '0;
        rxWord_q <= '0;
        slaveLoaded_q <= 1'b0;
      end
      else if (anyEdge)
      begin
        edgeCnt_q <= frameEnd ? '0 : edgeCnt_q + 1'b1;
        rxWord_q <= frameEnd ? '0 : rxWordD;
        if (frameEnd)
          slaveLoaded_q <= 1'b0;
      end
      if (state_q == ST_LOAD || slaveLoad)
      begin
        txWord_q <= loadWord;
        dataBit_q <= loadWord[firstPos];
        slaveLoaded_q <= isSlave;
      end
      else if (shiftEdge)
        dataBit_q <= txWord_q[txPos];
    end
  end

  // Pins and flags, all registered
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sckOut_q <= 1'b0;
      sckOe_q <= 1'b0;
      mosiOe_q <= 1'b0;
      misoOe_q <= 1'b0;
      nssOut_q <= 1'b0;
      nssOe_q <= 1'b0;
      rxFlag_q <= 1'b0;
      txFlag_q <= 1'b1;
      busy_q <= 1'b0;
    end
    else
    begin
      if (state_q != ST_SHIFT)
        sckOut_q <= clkPolarity;
      else if (masterEdge)
        sckOut_q <= !sckOut_q;
      sckOe_q <= isMaster;
      mosiOe_q <= isMaster && sendOn;
      misoOe_q <= isSlave && slaveSel && sendOn;
      nssOut_q <= pulseGap;
      nssOe_q <= isMaster && select_output_enable;
      rxFlag_q <= (rxLevel >= LW'(rxThr));
      txFlag_q <= (txLevel <= LW'(FIFO_DEPTH / 2));
      busy_q <= busyD;
    end
  end

  assign sckOut = sckOut_q;
  assign sckOe = sckOe_q;
  assign mosiOut = dataBit_q;
  assign misoOut = dataBit_q;
  assign mosiOe = mosiOe_q;
  assign misoOe = misoOe_q;
  assign nssOut = nssOut_q;
  assign nssOe = nssOe_q;
  assign rx_not_empty_flag = rxFlag_q;
  assign tx_empty_flag = txFlag_q;
  assign busy_flag = busy_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  idle_clock_level_a: assert property ((state_q == ST_IDLE) |=> (sckOut_q == $past(clkPolarity)))
    else $error("idle clock not at polarity level");
  disabled_pins_off_a: assert property (!port_enable |=> (!mosiOe_q && !misoOe_q && !sckOe_q))
    else $error("disabled port still drives pins");
  rx_only_release_a: assert property (receive_only |=> (!mosiOe_q && !misoOe_q))
    else $error("receive-only port drives send pin");
  rx_only_busy_a: assert property ((isMaster && contRx) |=> busy_q)
    else $error("receive-only master not busy");
  pulse_select_high_a: assert property ((pulseGap && isMaster) |=> nssOut_q)
    else $error("select not raised between frames");
  frame_right_align_a: assert property (rxPush |-> ((rxWordD >> word_size) >> 1) == '0)
    else $error("received bits beyond word size");
  master_drives_clock_a: assert property (isMaster |=> sckOe_q)
    else $error("master not driving clock");
  soft_deselect_a: assert property ((isSlave && soft_select_manage && internal_select_level)
      |=> !misoOe_q)
    else $error("soft-deselected slave drives data");
  select_output_low_a: assert property ((isMaster && select_output_enable && !pulseGap)
      |=> (nssOe_q && !nssOut_q))
    else $error("master select output not low");
  bidir_receive_a: assert property ((port_enable && bidirRx) |=> (!mosiOe_q && !misoOe_q))
    else $error("bidirectional receive drives line");
  clock_toggle_pair_a: assert property ((masterEdge && frameEnd) |=> (sckOut_q == clkPolarity))
    else $error("frame ended off idle level");
endmodule

// ==== dv/spi_far_model.sv ====
// Far-side slave model for a master-mode port; samples or shifts on every SCK edge.
// Assumes the bench resolves the pins and calls restart before each run.
`timescale 1ns/1ps
module spi_far_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic cpha,
  input wire logic lsb,
  input wire logic [3:0] ws,
  output logic miso
);
  logic [15:0] sendQ[$];
  logic [15:0] gotQ[$];
  logic [15:0] cur;
  logic [15:0] acc;
  int edgeN = 0;
  int frames = 0;
  function automatic int pos(int i);
    return lsb ? i : int'(ws) - i;
  endfunction
  task automatic load();
    edgeN = 0;
    acc = 16'h0000;
    cur = (sendQ.size() > 0) ? sendQ.pop_front() : 16'h0000;
    miso = cur[pos(0)];
  endtask
  task automatic restart();
    gotQ.delete();
    frames = 0;
    load();
  endtask
  // Counting edges, not levels, keeps one loop for all four modes
  always @(sck)
  begin
    edgeN++;
    if ((edgeN + cpha) % 2 == 1)
      acc[pos((edgeN - 1 - cpha) / 2)] = mosi;
    if (edgeN == 2 * (int'(ws) + 1))
    begin
      gotQ.push_back(acc);
      frames++;
      load();
    end
    else if ((edgeN + cpha) % 2 == 0)
      miso = cur[pos((edgeN - cpha) / 2)];
  end
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the serial port: master runs against a far model.
// Assumes the port, FIFO and synchroniser files are compiled before it.
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 0, rst = 1, port_enable = 0, master_select = 1;
  logic clkPolarity = 0, clkPhase = 0, low_bit_first = 0, rx_fill_threshold = 0;
  logic [3:0] word_size = 4'h7;
  // Half period must outlast the four-cycle pin synchroniser delay on returning data
  logic [2:0] baud_divider = 3'h3;
  logic soft_select_manage = 0, internal_select_level = 1, select_output_enable = 1;
  logic receive_only = 0, bidir_line_enable = 0, bidir_output_enable = 1;
  logic select_pulse_enable = 0, txValid = 0, rxReady = 0, tog = 0;
  logic nssDrv = 1;
  logic slaveSck = 0, mosiDrv = 0;
  logic [15:0] sw, sv, sm, sgot;
  logic [15:0] txData = 16'h0000;
  logic [15:0] rxData;
  logic txReady, rxValid, rx_not_empty_flag, tx_empty_flag, busy_flag, farMiso;
  logic sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, nssOut, nssOe;
  logic [15:0] expTx[$];
  logic [15:0] expRx[$];
  int numErrors = 0, totalChecks = 0, cyc = 0, pulses = 0, i, e, sb;
  // A released output data line shows a changing pattern so a stale value never passes
  wire logic sckIn = sckOe ? sckOut : (clkPolarity ^ slaveSck);
  wire logic mosiIn = mosiOe ? mosiOut : (master_select ? tog : mosiDrv);
  wire logic misoIn = misoOe ? misoOut : (master_select ? farMiso : tog);
  wire logic nssIn = nssOe ? nssOut : nssDrv;
  spi_port dut_u (.core_clk, .rst, .port_enable, .master_select, .clkPolarity,
    .clkPhase, .low_bit_first, .word_size, .baud_divider, .rx_fill_threshold,
    .soft_select_manage, .internal_select_level, .select_output_enable,
    .receive_only, .bidir_line_enable, .bidir_output_enable, .select_pulse_enable,
    .txData, .txValid, .txReady, .rxData, .rxValid, .rxReady, .rx_not_empty_flag,
    .tx_empty_flag, .busy_flag, .sckIn, .sckOut, .sckOe, .mosiIn, .mosiOut,
    .mosiOe, .misoIn, .misoOut, .misoOe, .nssIn, .nssOut, .nssOe);
  spi_far_model far_u (.sck(sckIn), .mosi(mosiIn), .cpha(clkPhase),
    .lsb(low_bit_first), .ws(word_size), .miso(farMiso));
  always #25 core_clk = ~core_clk;
  always @(posedge nssOut) pulses++;
  always @(posedge core_clk)
  begin
    tog <= ~tog;
    cyc++;
    if (cyc == 60000)
    begin
      numErrors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(logic [15:0] got, logic [15:0] exp, string what);
    totalChecks++;
    if (got !== exp)
    begin
      numErrors++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic settle(int n);
    repeat (n) @(negedge core_clk);
  endtask
  function automatic int bp(int b);
    return low_bit_first ? b : int'(word_size) - b;
  endfunction
  task automatic run_case(int mode, int lsb, int ws, int n, logic rxo, logic bid, logic p);
    logic [15:0] w, m;
    int k, cnt;
    port_enable = 0;
    settle(2);
    {clkPhase, clkPolarity} = mode[1:0];
    low_bit_first = lsb[0];
    word_size = ws[3:0];
    receive_only = rxo;
    bidir_line_enable = bid;
    select_pulse_enable = p;
    rx_fill_threshold = 1'($urandom);
    m = 16'hffff >> (15 - ws);
    settle(4);
    check(sckOut, clkPolarity, "parked clock");
    check({mosiOe, misoOe}, 2'b00, "pins released");
    far_u.sendQ.delete();
    for (k = 0; k < n; k++)
    begin
      w = 16'($urandom);
      far_u.sendQ.push_back(w);
      if (!bid)
        expRx.push_back(w & m);
      w = 16'($urandom);
      if (!rxo)
      begin
        check(txReady, 1, "tx room");
        expTx.push_back(w & m);
        txData = w;
        txValid = 1;
        settle(1);
      end
    end
    txValid = 0;
    if (n == 8)
    begin
      settle(2);
      check({txReady, tx_empty_flag}, 2'b00, "tx full");
    end
    far_u.restart();
    pulses = 0;
    port_enable = 1;
    settle(10);
    check(busy_flag, 1, "busy in frame");
    check({sckOe, mosiOe, misoOe}, {2'b11, 1'b0} ^ {1'b0, rxo, 1'b0}, "master pins");
    check({nssOe, nssOut}, 2'b10, "select out");
    k = 0;
    while ((far_u.frames < n || (!rxo && busy_flag !== 1'b0)) && k < 4000)
    begin
      settle(1);
      k++;
    end
    check(far_u.frames >= n, 1, "frame count");
    if (rxo)
    begin
      port_enable = 0;
      settle(4);
      cnt = far_u.frames;
      settle(40);
      check(far_u.frames == cnt && sckOut === clkPolarity, 1, "clock stops");
    end
    else
    begin
      check({busy_flag, tx_empty_flag}, 2'b01, "idle flags");
      check(sckOut, clkPolarity, "idle clock");
      for (k = 0; k < n; k++)
        check(far_u.gotQ[k], expTx[k], "far side word");
    end
    if (p)
      check(pulses >= n - 1, 1, "select pulses");
    cnt = expRx.size();
    while (cnt > 0)
    begin
      check(rx_not_empty_flag, cnt >= 1 + rx_fill_threshold, "rx threshold");
      check(rxValid, 1, "rx valid");
      check(rxData, expRx.pop_front(), "rx word");
      rxReady = 1;
      settle(1);
      rxReady = 0;
      settle(1);
      cnt--;
    end
    // Receive-only runs may capture extra words; flush so later runs start clean
    rxReady = 1;
    for (k = 0; k < 16 && rxValid === 1'b1; k++)
      settle(1);
    rxReady = 0;
    expTx.delete();
  endtask
  initial
  begin
    i = $urandom(32'h272a_01ac);
    settle(20);
    rst = 0;
    settle(1);
    for (i = 0; i < 4; i++)
      run_case(i, i % 2, 3 + 4 * i, 3, 0, 0, 0);
    run_case(3, 0, 7, 8, 0, 0, 1);
    run_case(1, 1, 4, 2, 1, 0, 0);
    run_case(2, 0, 9, 2, 0, 1, 0);
    port_enable = 0;
    settle(2);
    master_select = 0;
    bidir_line_enable = 0;
    soft_select_manage = 1;
    port_enable = 1;
    settle(8);
    check({sckOe, mosiOe, misoOe}, 3'b000, "slave unselected");
    internal_select_level = 0;
    settle(8);
    check({sckOe, mosiOe, misoOe}, 3'b001, "slave soft select");
    soft_select_manage = 0;
    settle(8);
    check(misoOe, 0, "slave pin high");
    nssDrv = 0;
    settle(8);
    check(misoOe, 1, "slave pin low");
    sw = 16'($urandom);
    sv = 16'($urandom);
    sm = 16'hffff >> (15 - word_size);
    sgot = 16'h0000;
    txData = sw;
    txValid = 1;
    settle(1);
    txValid = 0;
    settle(4);
    mosiDrv = sv[bp(0)];
    sb = -1;
    // The slave answers about five core cycles after an edge, so its bit is taken late
    for (e = 1; e <= 2 * int'(word_size) + 3; e++)
    begin
      if (sb >= 0)
        sgot[bp(sb)] = misoIn;
      sb = -1;
      if (e <= 2 * int'(word_size) + 2)
      begin
        slaveSck = ~slaveSck;
        if ((e % 2 == 1) != clkPhase)
          sb = (e - 1) / 2;
        else if (e / 2 <= int'(word_size))
          mosiDrv = sv[bp(e / 2)];
      end
      settle(4);
    end
    check(sgot, sw & sm, "slave sent word");
    check(rxValid, 1, "slave rx valid");
    check(rxData, sv & sm, "slave rx word");
    check(busy_flag, 0, "slave idle");
    bidir_line_enable = 1;
    bidir_output_enable = 0;
    settle(2);
    check({mosiOe, misoOe}, 2'b00, "bidir receive");
    final_report();
  end
endmodule
